//--- ram_pointer_and_config_regs_tb_top.sv
// bench of the pointer block against a bench model
`timescale 1ns/100ps
module ram_pointer_and_config_regs_tb_top;
  reg clk = 1'b0, reset = 1'b1, cyc_i = 1'b0, we_i = 1'b0, e;
  reg [5:0] adr_i = 6'h00;
  reg [31:0] dat_i = 32'h0, d, seed = 32'haafc;
  wire stb_i = cyc_i;
  wire [3:0] sel_i = 4'h1;
  wire [31:0] dat_o;
  wire [10:0] ram_addr;
  wire [7:0] ram_wdata, ram_rdata;
  wire [2:0] indirect_sel;
  wire ack_o, err_o, ram_we, ram_re, soft_reset, chained_command_enable;
  wire status_clear, next_id_clear, diag_clear, indirect_reserved;
  integer mismatches = 0, compares = 0, p, i, t;
  reg [7:0] q [$];
  rpc_regs uut (.*);
  rpc_ram_model ram (.*);
  initial forever #50 clk = ~clk;
  function [31:0] xs(input [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    xs = x ^ (x << 5);
  endfunction
  task chk(input string n, input [31:0] s, x);
    compares = compares + 1;
    if (s !== x) begin
      mismatches = mismatches + 1;
      $display("[FAIL] %s exp %h got %h", n, x, s);
    end
  endtask
  task wb(input w, input [5:0] a, input [7:0] v);
    @(posedge clk);
    cyc_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= {24'h0, v};
    t = 0;
    do begin @(posedge clk); t = t + 1; end
    while (!(ack_o | err_o) && t < 40);
    d = dat_o;
    e = err_o;
    cyc_i <= 1'b0;
    chk("ack", t < 40, 1);
  endtask
  task rd(input [5:0] a, input [7:0] x);
    wb(1'b0, a, 8'h00);
    chk("read", d, x);
  endtask
  task wrap_up;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    #1000000;
    mismatches = mismatches + 1;
    wrap_up;
  end
  initial begin
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    rd(6'h04, 8'h00);
    rd(6'h10, 8'h00);
    wb(1'b1, 6'h18, 8'h00);
    chk("err", e, 1);
    p = 2045;
    wb(1'b1, 6'h00, {5'h08, p[10:8]});
    wb(1'b1, 6'h04, p[7:0]);
    for (i = 0; i < 6; i = i + 1) begin
      seed = xs(seed);
      q.push_back(seed[7:0]);
      wb(1'b1, 6'h08, seed[7:0]);
    end
    p = (p + 6) % 2048;
    rd(6'h00, {5'h08, p[10:8]});
    rd(6'h04, p[7:0]);
    p = 2045;
    wb(1'b1, 6'h00, {5'h18, p[10:8]});
    wb(1'b1, 6'h04, p[7:0]);
    wb(1'b0, 6'h08, 8'h00);
    while (q.size() > 0) rd(6'h08, q.pop_front());
    p = (p + 7) % 2048;
    wb(1'b1, 6'h08, 8'h00);
    rd(6'h04, p[7:0]);
    wb(1'b1, 6'h00, {5'h10, p[10:8]});
    wb(1'b0, 6'h08, 8'h00);
    rd(6'h04, p[7:0]);
    for (i = 0; i < 8; i = i + 1) begin
      wb(1'b1, 6'h0C, i[7:0]);
      rd(6'h0C, i[7:0]);
      chk("sel", {indirect_reserved, indirect_sel}, {i > 4, i[2:0]});
    end
    wb(1'b1, 6'h10, 8'h43);
    rd(6'h0C, 8'h03);
    chk("chain", chained_command_enable, 1);
    wb(1'b1, 6'h10, 8'h80);
    chk("clr", {soft_reset, status_clear, diag_clear}, 3'h7);
    rd(6'h10, 8'h80);
    rd(6'h14, 8'h05);
    rd(6'h04, p[7:0]);
    wb(1'b1, 6'h10, 8'h00);
    chk("rel", {soft_reset, next_id_clear, chained_command_enable}, 0);
    // second reset in mid-run returns the pointer to zero
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    rd(6'h00, 8'h00);
    rd(6'h04, 8'h00);
    rd(6'h14, 8'h00);
    wrap_up;
  end
endmodule // ram_pointer_and_config_regs_tb_top

//--- rpc_chk.sv
// port checker of the pointer block
`timescale 1ns/100ps
module rpc_chk (input wire clk, reset, cyc_i, stb_i, we_i, ack_o, err_o,
  input wire [5:0] adr_i, input wire [3:0] sel_i, input wire [31:0] dat_i,
  input wire ram_we, ram_re, soft_reset, chained_command_enable,
  status_clear, next_id_clear, diag_clear, indirect_reserved,
  input wire [2:0] indirect_sel);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  wire cw = ack_o && we_i && sel_i[0] && adr_i == 6'h10;
  property p_ans; cyc_i && stb_i && !ack_o && !err_o |=> ack_o ^ err_o;
  endproperty
  a_ans: assert property (p_ans) else $error("no answer");
  property p_one; ack_o |=> !ack_o; endproperty
  a_one: assert property (p_one) else $error("long ack");
  property p_err; ack_o || err_o |-> err_o == $past(adr_i[5:2] > 4'h5);
  endproperty
  a_err: assert property (p_err) else $error("bad err");
  property p_clr;
    {status_clear, next_id_clear, diag_clear} == {3{soft_reset}};
  endproperty
  a_clr: assert property (p_clr) else $error("bad clear");
  property p_rsv; indirect_reserved == (indirect_sel > 3'h4); endproperty
  a_rsv: assert property (p_rsv) else $error("bad reserved");
  property p_rw; !(ram_we && ram_re); endproperty
  a_rw: assert property (p_rw) else $error("read and write");
  property p_cfg;
    cw |-> soft_reset == dat_i[7] && chained_command_enable == dat_i[6];
  endproperty
  a_cfg: assert property (p_cfg) else $error("bad config");
  property p_top; cw |-> ##[0:1] !indirect_sel[2]; endproperty
  a_top: assert property (p_top) else $error("top kept");
  c_cfg: cover property (cw);
  c_err: cover property (err_o);
  c_rd: cover property (ram_re);
endmodule // rpc_chk
bind rpc_regs rpc_chk u_chk (.*);

//--- rpc_consts.vh
// register offsets, field positions and reset values of the pointer block
`ifndef RPC_CONSTS_VH
`define RPC_CONSTS_VH
`define RPC_OFS_PTR_UPPER 4'h0
`define RPC_OFS_PTR_LOWER 4'h4
`define RPC_OFS_DATA 4'h8
`define RPC_OFS_SELECT 4'hC
`define RPC_ADR_CONFIG 6'h10
`define RPC_ADR_STATUS 6'h14
`define RPC_BIT_READ_DIR 7
`define RPC_BIT_STEP_EN 6
`define RPC_BIT_SW_RESET 7
`define RPC_BIT_CHAIN_EN 6
`define RPC_RST_UPPER 8'h00
`define RPC_RST_LOWER 8'h00
`define RPC_RST_CONFIG 8'h00
`define RPC_RST_SELECT 3'h0
`define RPC_SEL_TENT_ID 3'h0
`define RPC_SEL_NODE_ID 3'h1
`define RPC_SEL_SETUP1 3'h2
`define RPC_SEL_NEXT_ID 3'h3
`define RPC_SEL_SETUP2 3'h4
`endif

//--- rpc_ptr_step.v
// buffer pointer counter with load and auto-step
`timescale 1ns/100ps
module rpc_ptr_step (
  input wire clk,
  input wire reset,
  input wire load_high,
  input wire load_low,
  input wire [7:0] load_data,
  input wire step,
  output reg [10:0] ptr
);
  always @(posedge clk) begin
    if (reset) begin
      ptr <= 11'h000;
    end else if (load_high) begin
      ptr <= {load_data[2:0], ptr[7:0]};
    end else if (load_low) begin
      ptr <= {ptr[10:8], load_data};
    end else if (step) begin
      ptr <= ptr + 11'h001;
    end
  end
endmodule // rpc_ptr_step

//--- rpc_ram_model.sv
// buffer ram on the far side of the pointer block
`timescale 1ns/100ps
module rpc_ram_model (input wire clk, ram_we, ram_re,
  input wire [10:0] ram_addr, input wire [7:0] ram_wdata,
  output wire [7:0] ram_rdata);
  reg [7:0] mem [0:2047];
  // inverted when idle so a stale byte cannot pass
  assign ram_rdata = ram_re ? mem[ram_addr] : ~mem[ram_addr];
  always @(posedge clk) begin
    if (ram_we) mem[ram_addr] <= ram_wdata;
  end
endmodule // rpc_ram_model

//--- rpc_regs.v
// pointer, sub-address and configuration registers on wishbone
// Functional notes
// - direction bit picks read or write access
// - step enable advances pointer after access
// - upper pointer bits 2-0 give address 10-8
// - lower pointer gives address 7-0
// - select field chooses indirect register
// - reset bit starts soft reset, config kept
// - soft reset clears status, next id, diag
// - soft reset holds while bit is one
// - chain enable selects chaining mode
//
// Register access over Wishbone and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
`include "rpc_consts.vh"
module rpc_regs (
  input wire clk,
  input wire reset,
  input wire cyc_i,
  input wire stb_i,
  input wire we_i,
  input wire [5:0] adr_i,
  input wire [3:0] sel_i,
  input wire [31:0] dat_i,
  output reg [31:0] dat_o,
  output reg ack_o,
  output reg err_o,
  output reg [10:0] ram_addr,
  output reg ram_we,
  output reg ram_re,
  output reg [7:0] ram_wdata,
  input wire [7:0] ram_rdata,
  output reg [2:0] indirect_sel,
  output reg indirect_reserved,
  output wire soft_reset,
  output wire chained_command_enable,
  output wire status_clear,
  output wire next_id_clear,
  output wire diag_clear
);
  reg [7:0] ram_pointer_upper;
  reg [7:0] device_configuration;
  reg sel_top;
  reg [7:0] rdata_hold;
  wire [10:0] ptr;
  wire req;
  wire wr;
  wire rd;
  wire hit_data;
  wire do_access;
  wire [2:0] sel_field;
  reg [31:0] next_dat;
  reg next_err;

  function [0:0] is_reserved;
    input [2:0] code;
    begin
      is_reserved = (code > `RPC_SEL_SETUP2);
    end
  endfunction

  assign req = cyc_i & stb_i & ~ack_o & ~err_o;
  assign wr = req & we_i & sel_i[0];
  assign rd = req & ~we_i;
  assign hit_data = (adr_i[5:2] == `RPC_OFS_DATA >> 2);
  // an access happens only when the bus we_i agrees with the direction bit
  assign do_access = req & hit_data &
    (ram_pointer_upper[`RPC_BIT_READ_DIR] ? ~we_i : we_i);
  assign sel_field = {sel_top, device_configuration[1:0]};

  assign soft_reset = device_configuration[`RPC_BIT_SW_RESET];
  assign chained_command_enable =
    device_configuration[`RPC_BIT_CHAIN_EN];
  assign status_clear = soft_reset;
  assign next_id_clear = soft_reset;
  assign diag_clear = soft_reset;

  rpc_ptr_step u_ptr (
    .clk(clk),
    .reset(reset),
    .load_high(wr && adr_i == {2'b00, `RPC_OFS_PTR_UPPER}),
    .load_low(wr && adr_i == {2'b00, `RPC_OFS_PTR_LOWER}),
    .load_data(dat_i[7:0]),
    .step(do_access & ram_pointer_upper[`RPC_BIT_STEP_EN]),
    .ptr(ptr)
  );

  // upper pointer, config and select; soft reset leaves these alone
  always @(posedge clk) begin
    if (reset) begin
      ram_pointer_upper <= `RPC_RST_UPPER;
      device_configuration <= `RPC_RST_CONFIG;
      sel_top <= 1'b0;
    end else if (wr) begin
      if (adr_i == {2'b00, `RPC_OFS_PTR_UPPER}) begin
        ram_pointer_upper <= dat_i[7:0];
      end
      if (adr_i == {2'b00, `RPC_OFS_SELECT}) begin
        sel_top <= dat_i[2];
        device_configuration[1:0] <= dat_i[1:0];
      end
      if (adr_i == `RPC_ADR_CONFIG) begin
        device_configuration <= dat_i[7:0];
        sel_top <= 1'b0;
      end
    end
  end

  // register read mux and unmapped decode
  always @* begin
    next_dat = 32'h00000000;
    next_err = 1'b0;
    case (adr_i)
      {2'b00, `RPC_OFS_PTR_UPPER}: next_dat[7:0] =
        {ram_pointer_upper[7:6], 3'b000, ptr[10:8]};
      {2'b00, `RPC_OFS_PTR_LOWER}: next_dat[7:0] = ptr[7:0];
      {2'b00, `RPC_OFS_DATA}: next_dat[7:0] = rdata_hold;
      {2'b00, `RPC_OFS_SELECT}: next_dat[7:0] = {5'b00000, sel_field};
      `RPC_ADR_CONFIG: next_dat[7:0] = device_configuration;
      `RPC_ADR_STATUS: next_dat[2:0] = {soft_reset,
        indirect_reserved, ram_pointer_upper[`RPC_BIT_READ_DIR]};
      default: next_err = 1'b1;
    endcase
  end

  always @(posedge clk) begin
    if (reset) begin
      ack_o <= 1'b0;
      err_o <= 1'b0;
      dat_o <= 32'h00000000;
      ram_addr <= 11'h000;
      ram_we <= 1'b0;
      ram_re <= 1'b0;
      ram_wdata <= 8'h00;
      rdata_hold <= 8'h00;
      indirect_sel <= `RPC_RST_SELECT;
      indirect_reserved <= 1'b0;
    end else begin
      ack_o <= req & ~next_err;
      err_o <= req & next_err;
      if (rd) begin
        dat_o <= next_dat;
      end
      ram_addr <= ptr;
      ram_we <= do_access & we_i;
      ram_re <= do_access & ~we_i;
      if (do_access & we_i) begin
        ram_wdata <= dat_i[7:0];
      end
      if (ram_re) begin
        rdata_hold <= ram_rdata;
      end
      indirect_sel <= sel_field;
      indirect_reserved <= is_reserved(sel_field);
    end
  end
endmodule // rpc_regs
